//--- hdl/lsd_defines.vh
/*
  Constants of the LCD segment driver controller: clock rates, frame and blink
  dividers, the bus address and the command byte encoding.
  Assumes a single 50 MHz system clock and a nominal 1536 Hz LCD oscillator rate.
*/
`ifndef LSD_DEFINES_VH
`define LSD_DEFINES_VH

// Rates and dividers
`define LSD_CLK_HZ 50000000
`define LSD_LCD_OSC_HZ 1536
// Clock rate over the LCD oscillator rate, rounded down, sized for the tick counter
`define LSD_LCD_TICK_DIV 16'd32552
`define LSD_FRAME_DIV 5'd24
`define LSD_BLINK_RATIO_FAST 768
`define LSD_BLINK_RATIO_MID 1536
`define LSD_BLINK_RATIO_SLOW 3072

// Seven-bit slave address, write direction only
`define LSD_SLAVE_ADDR 7'h38

// Drive modes
`define LSD_MODE_STATIC 2'h0
`define LSD_MODE_MUX2 2'h1
`define LSD_MODE_MUX3 2'h2

// Blink rates
`define LSD_BLINK_OFF 2'h0
`define LSD_BLINK_FAST 2'h1
`define LSD_BLINK_MID 2'h2
`define LSD_BLINK_SLOW 2'h3

// Command byte: bit 7 clear means display data, else bits 6:5 select the command
`define LSD_CMD_FLAG 7
`define LSD_CMD_MODE 2'h0
`define LSD_CMD_BLINK 2'h1
`define LSD_CMD_BANK 2'h2
`define LSD_CMD_POINTER 2'h3
`define LSD_MODE_ENABLE_BIT 2
`define LSD_BLINK_ALT_BIT 2
`define LSD_BANK_IN_BIT 1
`define LSD_BANK_OUT_BIT 0

`endif

//--- hdl/lsd_ram.v
/*
  Display RAM, 32 words of 4 bits, with a masked write port and a
  registered read port.
  Assumes write and read addresses are stable in the cycle they are used.
*/
`timescale 1ns/100ps
`default_nettype none

module lsd_ram (
  // Clock
  input wire clock,
  // Write port
  input wire wrEn,
  input wire [4:0] wrAddr,
  input wire [3:0] wrMask,
  input wire [3:0] wrData,
  // Read port
  input wire [4:0] rdAddr,
  output reg [3:0] rdData
);

  reg [3:0] mem [0:31];

  // Masked write so bank loads leave the other bits intact
  always @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= (mem[wrAddr] & ~wrMask) | (wrData & wrMask);
    end
    rdData <= mem[rdAddr];
  end

endmodule // lsd_ram

`default_nettype wire

//--- hdl/lsd_controller.v
/*
  LCD segment driver controller: write-only two-wire slave, display RAM with
  data pointer and bank selectors, display latch, frame timing, backplane and
  segment waveforms, and blinking.
  Assumes bus pins are synchronous to the clock and an external pad resolves
  the open-drain data line from sdaOe.
*/
// Function
// R1 - Frame rate is the LCD oscillator rate divided by 24.
// R2 - A display latch holds data while multiplex signals are produced.
// R3 - 32 segment outputs from multiplex phase and latched bit.
// R4 - Four backplane outputs shaped by the selected drive mode.
// R5 - In 1:3 drive the fourth backplane copies the second.
// R6 - In 1:2 drive first equals third, second equals fourth.
// R7 - In static drive all four backplanes carry one signal.
// R8 - Display RAM holds 32 words of 4 bits.
// R9 - Bit 0 pairs with first backplane; bits 1-3 multiplex with others.
// R10 - RAM is written at the data pointer, single or consecutive bytes.
// R11 - Output bank shows bit 2 (static) or bits 2,3 (1:2) instead.
// R12 - Input bank stores into bit 2 or bits 2,3, independent of output.
// R13 - Whole-display blink off or at LCD rate over 768, 1536, 3072.
// R14 - Per-segment blink alternates main and alternative bank in static and 1:2.
// R15 - Display blanks while the enable bit is clear.
// R16 - Slave receiver only with subaddress fixed at zero.
// R17 - Answers address 0111 0000 for writes only, never reads.
// R18 - Commands are decoded from written bytes in a chosen encoding.
// R19 - Reset leaves display off, blinking off, both banks at zero.
`timescale 1ns/100ps
`default_nettype none
`include "lsd_defines.vh"

module lsd_controller #(
  parameter [15:0] LCD_TICK_DIV = `LSD_LCD_TICK_DIV
) (
  // Clock and reset
  input wire clock,
  input wire rst_b,
  // Two-wire bus
  input wire scl,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe,
  // LCD drive
  output reg [31:0] segmentOutputs,
  output reg backplaneFirst,
  output reg backplaneSecond,
  output reg backplaneThird,
  output reg backplaneFourth
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK = 3'h2;
  localparam [2:0] ST_DATA = 3'h3;
  localparam [2:0] ST_IGNORE = 3'h4;

  // Half period of the blink square wave in LCD ticks
  function [10:0] blinkHalf;
    input [1:0] rate;
    reg [31:0] full;
    begin
      case (rate)
        `LSD_BLINK_FAST: full = `LSD_BLINK_RATIO_FAST / 2;
        `LSD_BLINK_MID: full = `LSD_BLINK_RATIO_MID / 2;
        default: full = `LSD_BLINK_RATIO_SLOW / 2;
      endcase
      blinkHalf = full[10:0];
    end
  endfunction

  // Multiplex phase of a tick position inside the frame
  function [1:0] phaseOf;
    input [1:0] mode;
    input [4:0] cnt;
    begin
      case (mode)
        `LSD_MODE_MUX2: phaseOf = (cnt < 5'd12) ? 2'h0 : 2'h1;
        `LSD_MODE_MUX3: phaseOf = (cnt < 5'd8) ? 2'h0 : ((cnt < 5'd16) ? 2'h1 : 2'h2);
        default: phaseOf = 2'h0;
      endcase
    end
  endfunction

  // Logical backplane served by a physical backplane pin
  function [1:0] logicalBp;
    input [1:0] mode;
    input [1:0] pin;
    begin
      case (mode)
        `LSD_MODE_MUX2: logicalBp = {1'b0, pin[0]};
        `LSD_MODE_MUX3: logicalBp = (pin == 2'h3) ? 2'h1 : pin;
        default: logicalBp = 2'h0;
      endcase
    end
  endfunction

  // Bus front end
  reg sclPrev_q;
  reg sdaPrev_q;
  reg [2:0] state_q;
  reg [3:0] bitCnt_q;
  reg [7:0] shift_q;
  reg byteDone_q;
  // Configuration
  reg [1:0] driveMode_q;
  reg dispEnable_q;
  reg [1:0] blinkRate_q;
  reg altBlink_q;
  reg inBank_q;
  reg outBank_q;
  reg [4:0] pointer_q;
  // RAM write
  reg ramWrEn_q;
  reg [4:0] ramWrAddr_q;
  reg [3:0] ramWrMask_q;
  reg [3:0] ramWrData_q;
  // Timing
  reg [15:0] tickDiv_q;
  reg lcdTick_q;
  reg [4:0] frameCnt_q;
  reg frameInv_q;
  reg [10:0] blinkCnt_q;
  reg blinkPhase_q;
  // Latch refresh
  reg scanBusy_q;
  reg [5:0] scanCnt_q;
  reg [31:0] latch_q [0:3];

  wire [3:0] ramRdData;
  wire sclRise = scl & ~sclPrev_q;
  wire sclFall = ~scl & sclPrev_q;
  wire startCond = scl & sclPrev_q & sdaPrev_q & ~sdaIn;
  wire stopCond = scl & sclPrev_q & ~sdaPrev_q & sdaIn;

  // R8 display RAM
  lsd_ram uRam (
    .clock(clock),
    .wrEn(ramWrEn_q),
    .wrAddr(ramWrAddr_q),
    .wrMask(ramWrMask_q),
    .wrData(ramWrData_q),
    .rdAddr(scanCnt_q[4:0]),
    .rdData(ramRdData)
  );

  // R16 receive-only slave; no transmit path exists
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      state_q <= ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      byteDone_q <= 1'b0;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
    end else begin
      sclPrev_q <= scl;
      sdaPrev_q <= sdaIn;
      byteDone_q <= 1'b0;
      if (startCond) begin
        state_q <= ST_ADDR;
        bitCnt_q <= 4'h0;
        sdaOe <= 1'b0;
      end else if (stopCond) begin
        state_q <= ST_IDLE;
        sdaOe <= 1'b0;
      end else begin
        case (state_q)
          ST_ADDR, ST_DATA: begin
            if (sclRise && bitCnt_q != 4'h8) begin
              shift_q <= {shift_q[6:0], sdaIn};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall && bitCnt_q == 4'h8) begin
              // R17 only the write address is acknowledged
              if (state_q == ST_DATA || shift_q == {`LSD_SLAVE_ADDR, 1'b0}) begin
                sdaOe <= 1'b1;
                byteDone_q <= (state_q == ST_DATA);
                state_q <= ST_ACK;
              end else begin
                state_q <= ST_IGNORE;
              end
            end
          end
          ST_ACK: begin
            if (sclFall) begin
              sdaOe <= 1'b0;
              bitCnt_q <= 4'h0;
              state_q <= ST_DATA;
            end
          end
          ST_IDLE, ST_IGNORE: begin
            sdaOe <= 1'b0;
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // R18 command decode; R19 reset defaults
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      driveMode_q <= `LSD_MODE_STATIC;
      dispEnable_q <= 1'b0;
      blinkRate_q <= `LSD_BLINK_OFF;
      altBlink_q <= 1'b0;
      inBank_q <= 1'b0;
      outBank_q <= 1'b0;
      pointer_q <= 5'h00;
      ramWrEn_q <= 1'b0;
      ramWrAddr_q <= 5'h00;
      ramWrMask_q <= 4'h0;
      ramWrData_q <= 4'h0;
    end else begin
      ramWrEn_q <= 1'b0;
      if (byteDone_q) begin
        if (!shift_q[`LSD_CMD_FLAG]) begin
          // R10 write at pointer, then advance for consecutive bytes
          ramWrEn_q <= 1'b1;
          ramWrAddr_q <= pointer_q;
          pointer_q <= pointer_q + 5'h01;
          case (driveMode_q)
            // R12 input bank chooses the stored bits in static and 1:2
            `LSD_MODE_STATIC: begin
              ramWrMask_q <= inBank_q ? 4'h4 : 4'h1;
              ramWrData_q <= inBank_q ? {1'b0, shift_q[0], 2'h0} : {3'h0, shift_q[0]};
            end
            `LSD_MODE_MUX2: begin
              ramWrMask_q <= inBank_q ? 4'hc : 4'h3;
              ramWrData_q <= inBank_q ? {shift_q[1:0], 2'h0} : {2'h0, shift_q[1:0]};
            end
            default: begin
              ramWrMask_q <= 4'h7;
              ramWrData_q <= {1'b0, shift_q[2:0]};
            end
          endcase
        end else begin
          case (shift_q[6:5])
            `LSD_CMD_MODE: begin
              dispEnable_q <= shift_q[`LSD_MODE_ENABLE_BIT];
              driveMode_q <= (shift_q[1:0] == 2'h3) ? `LSD_MODE_MUX3 : shift_q[1:0];
            end
            `LSD_CMD_BLINK: begin
              blinkRate_q <= shift_q[1:0];
              altBlink_q <= shift_q[`LSD_BLINK_ALT_BIT];
            end
            `LSD_CMD_BANK: begin
              inBank_q <= shift_q[`LSD_BANK_IN_BIT];
              outBank_q <= shift_q[`LSD_BANK_OUT_BIT];
            end
            default: begin
              pointer_q <= shift_q[4:0];
            end
          endcase
        end
      end
    end
  end

  // R1 LCD tick and frame of 24 ticks; polarity flips each frame to keep DC off the glass
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tickDiv_q <= 16'h0000;
      lcdTick_q <= 1'b0;
      frameCnt_q <= 5'h00;
      frameInv_q <= 1'b0;
      blinkCnt_q <= 11'h000;
      blinkPhase_q <= 1'b0;
    end else begin
      lcdTick_q <= (tickDiv_q == LCD_TICK_DIV - 16'h0001);
      tickDiv_q <= (tickDiv_q == LCD_TICK_DIV - 16'h0001) ? 16'h0000 : tickDiv_q + 16'h0001;
      if (lcdTick_q) begin
        if (frameCnt_q == `LSD_FRAME_DIV - 5'd1) begin
          frameCnt_q <= 5'h00;
          frameInv_q <= ~frameInv_q;
        end else begin
          frameCnt_q <= frameCnt_q + 5'h01;
        end
        // R13 blink square wave, each half lasting half the ratio
        if (blinkRate_q == `LSD_BLINK_OFF) begin
          blinkCnt_q <= 11'h000;
          blinkPhase_q <= 1'b0;
        end else if (blinkCnt_q >= blinkHalf(blinkRate_q) - 11'h001) begin
          blinkCnt_q <= 11'h000;
          blinkPhase_q <= ~blinkPhase_q;
        end else begin
          blinkCnt_q <= blinkCnt_q + 11'h001;
        end
      end
    end
  end

  // R2 latch refresh in the second lcd tick of each frame; RAM writes after the refresh wait for the next frame
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scanBusy_q <= 1'b0;
      scanCnt_q <= 6'h00;
      latch_q[0] <= 32'h00000000;
      latch_q[1] <= 32'h00000000;
      latch_q[2] <= 32'h00000000;
      latch_q[3] <= 32'h00000000;
    end else if (!scanBusy_q) begin
      scanCnt_q <= 6'h00;
      scanBusy_q <= lcdTick_q && frameCnt_q == 5'h00;
    end else begin
      scanCnt_q <= scanCnt_q + 6'h01;
      if (scanCnt_q != 6'h00) begin
        latch_q[0][scanCnt_q[4:0] - 5'h01] <= ramRdData[0];
        latch_q[1][scanCnt_q[4:0] - 5'h01] <= ramRdData[1];
        latch_q[2][scanCnt_q[4:0] - 5'h01] <= ramRdData[2];
        latch_q[3][scanCnt_q[4:0] - 5'h01] <= ramRdData[3];
      end
      if (scanCnt_q == 6'd32) begin
        scanBusy_q <= 1'b0;
      end
    end
  end

  // Waveform selection
  reg [1:0] phase;
  reg bankSel;
  reg [1:0] bitSel;
  reg blank;
  reg [31:0] lit;
  always @* begin
    phase = phaseOf(driveMode_q, frameCnt_q);
    // R14 alternate bank toggles at the blink rate in static and 1:2
    bankSel = outBank_q ^ (altBlink_q && blinkPhase_q && driveMode_q != `LSD_MODE_MUX3);
    // R9 bit index follows the phase; R11 output bank adds two
    bitSel = (driveMode_q != `LSD_MODE_MUX3 && bankSel) ? phase + 2'h2 : phase;
    // R15 enable bit blanks; R13 whole-display blink blanks on alternate halves
    blank = !dispEnable_q || (!altBlink_q && blinkPhase_q);
    lit = blank ? 32'h00000000 : latch_q[bitSel];
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      segmentOutputs <= 32'hffffffff;
      backplaneFirst <= 1'b0;
      backplaneSecond <= 1'b0;
      backplaneThird <= 1'b0;
      backplaneFourth <= 1'b0;
    end else begin
      // R3 segment is driven opposite the active backplane when lit
      segmentOutputs <= {32{frameInv_q}} ^ ~lit;
      // R4 R5 R6 R7 pins follow their logical backplane per mode
      backplaneFirst <= frameInv_q ^ (logicalBp(driveMode_q, 2'h0) == phase);
      backplaneSecond <= frameInv_q ^ (logicalBp(driveMode_q, 2'h1) == phase);
      backplaneThird <= frameInv_q ^ (logicalBp(driveMode_q, 2'h2) == phase);
      backplaneFourth <= frameInv_q ^ (logicalBp(driveMode_q, 2'h3) == phase);
    end
  end

endmodule // lsd_controller

`default_nettype wire

//--- dv/lsd_controller_assertions.sv
/*
  Port checker for the LCD segment driver controller.
  Assumes it is bound to lsd_controller and that the data line resolves outside.
*/
`timescale 1ns/100ps
`default_nettype none
module lsd_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Bus
  input wire logic scl,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // LCD drive
  input wire logic [31:0] segmentOutputs,
  input wire logic backplaneFirst,
  input wire logic backplaneSecond,
  input wire logic backplaneThird,
  input wire logic backplaneFourth
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  chk_sda_drive: assert property (sdaOut == 1'b0) else $error("data drive not low");
  chk_bp_fourth: assert property (backplaneFourth == backplaneSecond) else $error("fourth backplane differs");
  chk_reset_unlit: assert property ($rose(rst_b) |-> segmentOutputs == 32'hffffffff)
    else $error("segments lit after reset");
  chk_reset_quiet: assert property ($rose(rst_b) |-> !sdaOe && !backplaneFirst && !backplaneThird)
    else $error("outputs busy after reset");
  chk_ack_rise: assert property ($rose(sdaOe) |-> !scl && !$past(scl)) else $error("ack not in low phase");
  chk_ack_end: assert property (sdaOe && $fell(scl) |-> ##[1:2] !sdaOe) else $error("ack held too long");
  chk_ack_fall: assert property ($fell(sdaOe) |-> !scl) else $error("ack dropped early");
  // First backplane steps are at least five clock cycles apart
  chk_bp_spacing: assert property ($changed(backplaneFirst) |=> $stable(backplaneFirst)[*4])
    else $error("backplane changes too fast");
endmodule // lsd_checker
bind lsd_controller lsd_checker lsd_checker_inst (.clock(clock), .rst_b(rst_b), .scl(scl), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .segmentOutputs(segmentOutputs), .backplaneFirst(backplaneFirst),
  .backplaneSecond(backplaneSecond), .backplaneThird(backplaneThird), .backplaneFourth(backplaneFourth));
`default_nettype wire

//--- dv/lsd_i2c_master.sv
/*
  Two-wire bus master model, write transfers only.
  Assumes the data line has a pull-up and is resolved by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module lsd_i2c_master #(
  parameter int HALF = 4
) (
  // Clock
  input wire logic clock,
  // Bus lines
  output logic scl,
  output logic sdaDrv,
  input wire logic sdaLine
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic startCond;
    scl = 1'b0;
    hold(1);
    sdaDrv = 1'b1;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sdaDrv = 1'b0;
    hold(HALF);
  endtask
  task automatic stopCond;
    scl = 1'b0;
    hold(1);
    sdaDrv = 1'b0;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sdaDrv = 1'b1;
    hold(HALF);
  endtask
  // one byte, data changes only while clock low
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      scl = 1'b0;
      hold(1);
      sdaDrv = b[i];
      hold(HALF);
      scl = 1'b1;
      hold(HALF);
    end
    scl = 1'b0;
    hold(1);
    sdaDrv = 1'b1;
    hold(HALF);
    scl = 1'b1;
    hold(HALF / 2);
    ack = !sdaLine;
    hold(HALF / 2);
  endtask
endmodule // lsd_i2c_master
`default_nettype wire

//--- dv/lsd_controller_tb.sv
/*
  Self-checking bench for the LCD segment driver controller.
  Assumes a four-clock lcd tick so frames are short.
*/
`timescale 1ns/100ps
`default_nettype none
module lsd_controller_tb;
  localparam int DIV = 4;
  localparam int FRAME = 24 * DIV;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic scl, sdaDrv, sdaLine, sdaOut, sdaOe, bp1, bp2, bp3, bp4;
  logic [31:0] seg;
  logic [31:0] pat = 32'h5a3c96e1;
  logic [31:0] v;
  int num_errors = 0;
  int checked = 0;
  // Pull-up on the open-drain data line
  assign sdaLine = sdaDrv & ~sdaOe;
  always #10 clock = ~clock;
  lsd_controller #(.LCD_TICK_DIV(16'd4)) lsd_controller_inst (.clock(clock), .rst_b(rst_b), .scl(scl),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .segmentOutputs(seg), .backplaneFirst(bp1),
    .backplaneSecond(bp2), .backplaneThird(bp3), .backplaneFourth(bp4));
  lsd_i2c_master lsd_i2c_master_inst (.clock(clock), .scl(scl), .sdaDrv(sdaDrv), .sdaLine(sdaLine));
  task automatic cmp(input logic [31:0] got, input logic [31:0] want, input string what);
    checked++;
    if (got !== want) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic wantAck);
    logic ack;
    lsd_i2c_master_inst.sendByte(b, ack);
    cmp(32'(ack), 32'(wantAck), "acknowledge");
  endtask
  task automatic cmd(input logic [7:0] c);
    lsd_i2c_master_inst.startCond();
    send(8'h70, 1'b1);
    send(c, 1'b1);
    lsd_i2c_master_inst.stopCond();
  endtask
  task automatic writeRun(input logic [4:0] ptr, input int n, input logic [31:0] bits);
    logic [4:0] a;
    a = ptr;
    lsd_i2c_master_inst.startCond();
    send(8'h70, 1'b1);
    send({3'h7, ptr}, 1'b1);
    repeat (n) begin
      send({7'h0, bits[a]}, 1'b1);
      a = a + 5'h1;
    end
    lsd_i2c_master_inst.stopCond();
  endtask
  // Static drive only: a lit segment differs from the backplane
  task automatic showLit(input logic [31:0] want, input string what);
    repeat (2 * FRAME) @(negedge clock);
    cmp(seg ^ {32{bp1}}, want, what);
  endtask
  function automatic logic blankNow();
    return (seg ^ {32{bp1}}) === 32'h0;
  endfunction
  task automatic testAddress;
    lsd_i2c_master_inst.startCond();
    send(8'h71, 1'b0);
    send(8'h84, 1'b0);
    lsd_i2c_master_inst.startCond();
    send(8'h72, 1'b0);
    lsd_i2c_master_inst.stopCond();
    showLit(32'h0, "display after refused write");
    cmp(32'(bp1 ^ bp3), 32'h0, "static backplanes");
  endtask
  task automatic testData;
    cmd(8'h84);
    writeRun(5'h1f, 33, pat);
    showLit(pat, "static pattern");
    cmd(8'hc2);
    writeRun(5'h00, 32, ~pat);
    showLit(pat, "input bank");
    cmd(8'hc1);
    showLit(~pat, "output bank");
    cmd(8'hc0);
    cmd(8'h80);
    showLit(32'h0, "display disabled");
    cmd(8'h84);
    showLit(pat, "display enabled");
  endtask
  task automatic testModes;
    int pairBad;
    int split;
    pairBad = 0;
    split = 0;
    cmd(8'h85);
    repeat (4 * FRAME) begin
      @(negedge clock);
      if (bp1 !== bp3 || bp2 !== bp4) pairBad++;
    end
    cmd(8'h86);
    repeat (4 * FRAME) begin
      @(negedge clock);
      if (bp2 !== bp4) pairBad++;
      if (bp1 !== bp2) split++;
    end
    cmp(32'(pairBad), 32'h0, "paired backplanes");
    cmp(32'(split > 0), 32'h1, "backplanes differ in 1:3");
    cmd(8'h84);
  endtask
  task automatic testBlink;
    int half;
    int n;
    for (int r = 1; r <= 3; r++) begin
      half = (384 << (r - 1)) * DIV;
      cmd(8'ha0 | 8'(r));
      n = 0;
      while (n < 2 * half && blankNow()) begin
        @(negedge clock);
        n++;
      end
      n = 0;
      while (n < 2 * half && !blankNow()) begin
        @(negedge clock);
        n++;
      end
      n = 0;
      while (n < 2 * half && blankNow()) begin
        @(negedge clock);
        n++;
      end
      cmp(32'(n >= half - FRAME && n <= half + FRAME), 32'h1, "blink half period");
    end
    cmd(8'ha0);
  endtask
  // Per-segment blink: shown data swaps between banks and never blanks
  task automatic testAltBlink;
    int n;
    logic [1:0] seen;
    n = 0;
    seen = 2'h0;
    cmd(8'ha5);
    repeat (4 * 384 * DIV) begin
      @(negedge clock);
      if ((seg ^ {32{bp1}}) === ~pat) seen[0] = 1'b1;
      if ((seg ^ {32{bp1}}) === pat && seen[0]) seen[1] = 1'b1;
      if (blankNow()) n++;
    end
    cmp(32'(seen), 32'h3, "bank alternation");
    cmp(32'(n), 32'h0, "blanking during bank blink");
    cmd(8'ha0);
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clock);
    rst_b = 1'b1;
    testAddress();
    testData();
    testModes();
    testBlink();
    testAltBlink();
    end_sim();
  end
  // Whole run is near 38000 cycles; margin kept under the cycle budget
  initial begin
    repeat (90000) @(posedge clock);
    num_errors++;
    end_sim();
  end
endmodule // lsd_controller_tb
`default_nettype wire
